// file: common/sleep_ctl_regs.svh
// register offsets, field positions, reset values and timing figures
// of the sleep mode controller; included by bare name, definitions only
`ifndef SLEEP_CTL_REGS_SVH
`define SLEEP_CTL_REGS_SVH

// byte offsets on the register port
`define REG_CTRL      8'h00
`define REG_IDLE      8'h04
`define REG_STATUS    8'h08
`define REG_LVL_FIRST 8'h10
`define REG_LVL_END   8'h50

// field positions
`define CTRL_EN_BIT     0
`define STATUS_MODE_LSB 0
`define STATUS_LVL_LSB  4
`define LVL_ADDR_LSB    4
`define FLD_ADDR_LSB    2

// per-level field selects inside a level block
`define FLD_SLEEP  2'h0
`define FLD_THRESH 2'h1
`define FLD_RESID  2'h2

// reset values
`define CTRL_RST   1'b0
`define IDLE_RST   16'h0064
`define SLEEP_RST  16'h0064
`define THRESH_RST 16'h0001
`define RESID_RST  16'h03e8

// timing: clock rate, millisecond tick and motion check length
`define CLK_MHZ       100
`define TICK_TIME_US  1000
`define CHECK_TIME_US 2900

`endif

// file: common/sleep_ctl_pkg.sv
// types shared by the sleep mode controller and its parameter store
// assumes nothing of its surroundings
package sleep_ctl_pkg;

   // power mode, one-hot
   typedef enum logic [2:0] {
      ST_TRACK = 3'b001,
      ST_INACT = 3'b010,
      ST_CHECK = 3'b100
   } pmode_t;

   typedef logic [1:0] level_t;

endpackage

// file: common/param_bus_if.sv
// carrier between the controller and its per-level parameter store
// assumes both ends run on the same clock
`timescale 1ns/100ps
`default_nettype none

interface param_bus_if #(parameter int PW = 16);
   logic                  wr_en;
   sleep_ctl_pkg::level_t wr_lvl;
   logic [1:0]            wr_fld;
   logic [PW-1:0]         wr_data;
   sleep_ctl_pkg::level_t sw_lvl;
   logic [1:0]            sw_fld;
   logic [PW-1:0]         sw_data;
   sleep_ctl_pkg::level_t fsm_lvl;
   logic [PW-1:0]         fsm_sleep;
   logic [PW-1:0]         fsm_thresh;
   logic [PW-1:0]         fsm_resid;

   modport ctrl (output wr_en, wr_lvl, wr_fld, wr_data, sw_lvl, sw_fld, fsm_lvl,
                 input sw_data, fsm_sleep, fsm_thresh, fsm_resid);
   modport mem  (input wr_en, wr_lvl, wr_fld, wr_data, sw_lvl, sw_fld, fsm_lvl,
                 output sw_data, fsm_sleep, fsm_thresh, fsm_resid);
endinterface

`default_nettype wire

// file: core/level_param_mem.sv
// four sets of sleep level settings with registered read ports
// assumes writes come from the controller's register port, same clock
`timescale 1ns/100ps
`default_nettype none
`include "sleep_ctl_regs.svh"

module level_param_mem #(
   parameter int PW = 16
)(
   // clock and reset
   input  wire logic    mclk,
   input  wire logic    rstn,
   // controller side
   param_bus_if.mem     pb
);
   logic [PW-1:0] sleep_t  [4];
   logic [PW-1:0] thresh_t [4];
   logic [PW-1:0] resid_t  [4];

   // one storage slot per level
   for (genvar g = 0; g < 4; g++) begin : g_lvl
      always_ff @(posedge mclk) begin
         if (!rstn) begin
            sleep_t[g]  <= `SLEEP_RST;
            thresh_t[g] <= `THRESH_RST;
            resid_t[g]  <= `RESID_RST;
         end else if (pb.wr_en && pb.wr_lvl == 2'(g)) begin
            if (pb.wr_fld == `FLD_SLEEP)  sleep_t[g]  <= pb.wr_data;
            if (pb.wr_fld == `FLD_THRESH) thresh_t[g] <= pb.wr_data;
            if (pb.wr_fld == `FLD_RESID)  resid_t[g]  <= pb.wr_data;
         end
      end
   end

   // software read port, data one cycle after the address
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         pb.sw_data <= '0;
      end else begin
         unique case (pb.sw_fld)
            `FLD_SLEEP:  pb.sw_data <= sleep_t[pb.sw_lvl];
            `FLD_THRESH: pb.sw_data <= thresh_t[pb.sw_lvl];
            `FLD_RESID:  pb.sw_data <= resid_t[pb.sw_lvl];
            default:     pb.sw_data <= '0;
         endcase
      end
   end

   // sequencer read port, follows the current level one cycle late
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         pb.fsm_sleep  <= `SLEEP_RST;
         pb.fsm_thresh <= `THRESH_RST;
         pb.fsm_resid  <= `RESID_RST;
      end else begin
         pb.fsm_sleep  <= sleep_t[pb.fsm_lvl];
         pb.fsm_thresh <= thresh_t[pb.fsm_lvl];
         pb.fsm_resid  <= resid_t[pb.fsm_lvl];
      end
   end
endmodule

`default_nettype wire

// file: core/sleep_mode_controller.sv
// sleep mode controller: moves the sensor among tracking, inactive and
// motion check, stepping through four sleep levels on its own
// assumes motion reports come from same-clock logic of the front end
//
// Behaviour
// - tracking mode senses motion continuously
// - inactive stops sensing, timer wakes device
// - stay inactive sleep time, then check
// - motion found in check enters tracking
// - no motion in check returns inactive
// - wake only when motion reaches threshold
// - four independent sleep level setting sets
// - each level: sleep, threshold, residence
// - residence elapsed moves to next level
// - level transitions run without firmware
// - firmware enable; disabled means always tracking
// - motion check lasts about 2.9 ms
//
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "sleep_ctl_regs.svh"

module sleep_mode_controller #(
   parameter int PW        = 16,
   parameter int TICK_CYC  = `TICK_TIME_US * `CLK_MHZ,
   parameter int CHECK_CYC = `CHECK_TIME_US * `CLK_MHZ
)(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rstn,
   // register port
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [31:0] rdata,
   // motion front end
   input  wire logic        motion_valid,
   input  wire logic [15:0] motion_mag,
   // power state
   output logic             sense_en,
   output logic             wake_pulse,
   output logic      [2:0]  mode,
   output logic      [1:0]  level_out
);
   localparam int TW = $clog2(TICK_CYC + 1);
   localparam int CW = $clog2(CHECK_CYC + 1);
   localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYC - 1);
   localparam logic [CW-1:0] CHK_LAST  = CW'(CHECK_CYC - 1);
   localparam sleep_ctl_pkg::level_t LAST_LVL = 2'h3;

   sleep_ctl_pkg::pmode_t state;
   sleep_ctl_pkg::pmode_t next_state;
   sleep_ctl_pkg::level_t level;
   sleep_ctl_pkg::level_t next_level;
   logic                  enable;
   logic [PW-1:0]         idle_time;
   logic [TW-1:0]         tick_cnt;
   logic [PW-1:0]         ms_cnt;
   logic [PW-1:0]         res_cnt;
   logic [CW-1:0]         chk_cnt;
   logic [PW:0]           accum;
   logic [31:0]           rdata_q;
   logic                  rd_mem;
   logic                  ms_tick;
   logic                  is_lvl;
   logic                  chg;

   param_bus_if #(.PW(PW)) pb ();

   // four level slots, three settings each
   level_param_mem #(.PW(PW)) u_mem (
      .mclk (mclk),
      .rstn (rstn),
      .pb   (pb.mem)
   );

   // level window decode: four blocks of 16 bytes, three words used
   assign is_lvl = (addr >= `REG_LVL_FIRST) && (addr < `REG_LVL_END)
                   && (addr[3:2] != 2'h3) && (addr[1:0] == 2'h0);

   // writes into the parameter store, and the addresses of both its read ports
   assign pb.wr_en   = wr && is_lvl;
   assign pb.wr_lvl  = 2'(addr[7:`LVL_ADDR_LSB] - 4'h1);
   assign pb.wr_fld  = addr[3:`FLD_ADDR_LSB];
   assign pb.wr_data = wdata[PW-1:0];
   assign pb.sw_lvl  = 2'(addr[7:`LVL_ADDR_LSB] - 4'h1);
   assign pb.sw_fld  = addr[3:`FLD_ADDR_LSB];
   assign pb.fsm_lvl = level;

   // control registers written by firmware
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         enable    <= `CTRL_RST;
         idle_time <= `IDLE_RST;
      end else if (wr) begin
         if (addr == `REG_CTRL) enable    <= wdata[`CTRL_EN_BIT];
         if (addr == `REG_IDLE) idle_time <= wdata[PW-1:0];
      end
   end

   // read data, stands only in the cycle after the strobe
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         rdata_q <= 32'h0000_0000;
         rd_mem  <= 1'b0;
      end else begin
         rd_mem  <= rd && is_lvl;
         rdata_q <= 32'h0000_0000;
         if (rd) begin
            if (addr == `REG_CTRL)
               rdata_q[`CTRL_EN_BIT] <= enable;
            if (addr == `REG_IDLE)
               rdata_q[PW-1:0] <= idle_time;
            if (addr == `REG_STATUS) begin
               rdata_q[`STATUS_MODE_LSB +: 3] <= state;
               rdata_q[`STATUS_LVL_LSB +: 2]  <= level;
            end
         end
      end
   end

   // parameter words come from the store's own output register
   assign rdata = rd_mem ? {{(32-PW){1'b0}}, pb.sw_data} : rdata_q;

   // millisecond time base, restarted on each mode change so that
   // sleep time and the idle time after a mode change are not cut short by a partial tick
   assign chg     = (next_state != state);
   assign ms_tick = (tick_cnt == TICK_LAST);

   always_ff @(posedge mclk) begin
      if (!rstn || chg || ms_tick) tick_cnt <= '0;
      else                         tick_cnt <= tick_cnt + 1'b1;
   end

   // time in the current mode; motion in tracking restarts idle time
   always_ff @(posedge mclk) begin
      if (!rstn || chg) begin
         ms_cnt <= '0;
      end else if (state == sleep_ctl_pkg::ST_TRACK && motion_valid) begin
         ms_cnt <= '0;
      end else if (ms_tick && ms_cnt != '1) begin
         ms_cnt <= ms_cnt + 1'b1;
      end
   end

   // residence at the current level, counts through inactive and check
   always_ff @(posedge mclk) begin
      if (!rstn || next_level != level
          || state == sleep_ctl_pkg::ST_TRACK) begin
         res_cnt <= '0;
      end else if (ms_tick && res_cnt != '1) begin
         res_cnt <= res_cnt + 1'b1;
      end
   end

   // length of the motion check, held at its last count
   always_ff @(posedge mclk) begin
      if (!rstn || state != sleep_ctl_pkg::ST_CHECK) chk_cnt <= '0;
      else if (chk_cnt != CHK_LAST)                  chk_cnt <= chk_cnt + 1'b1;
   end

   // motion gathered during a check; saturates instead of wrapping
   always_ff @(posedge mclk) begin
      if (!rstn || state != sleep_ctl_pkg::ST_CHECK) begin
         accum <= '0;
      end else if (motion_valid) begin
         if (accum + {1'b0, motion_mag[PW-1:0]} < accum) accum <= '1;
         else accum <= accum + {1'b0, motion_mag[PW-1:0]};
      end
   end

   // mode sequencer, runs with no firmware help
   always_comb begin
      next_state = state;
      next_level = level;
      unique case (state)
         sleep_ctl_pkg::ST_TRACK: begin
            // quiet long enough: drop to first level
            if (ms_cnt >= idle_time && !motion_valid) begin
               next_state = sleep_ctl_pkg::ST_INACT;
               next_level = 2'h0;
            end
         end
         sleep_ctl_pkg::ST_INACT: begin
            if (ms_cnt >= pb.fsm_sleep)
               next_state = sleep_ctl_pkg::ST_CHECK;
         end
         sleep_ctl_pkg::ST_CHECK: begin
            if (accum >= {1'b0, pb.fsm_thresh}) begin
               next_state = sleep_ctl_pkg::ST_TRACK;
               next_level = 2'h0;
            end else if (chk_cnt == CHK_LAST) begin
               next_state = sleep_ctl_pkg::ST_INACT;
               // step down once residence is used up
               if (res_cnt >= pb.fsm_resid && level != LAST_LVL)
                  next_level = level + 2'h1;
            end
         end
      endcase
      // disabled: pinned in tracking, no wake latency
      if (!enable) begin
         next_state = sleep_ctl_pkg::ST_TRACK;
         next_level = 2'h0;
      end
   end

   // mode and level registers
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         state <= sleep_ctl_pkg::ST_TRACK;
         level <= 2'h0;
      end else begin
         state <= next_state;
         level <= next_level;
      end
   end

   // sensing is off only while inactive
   always_ff @(posedge mclk) begin
      if (!rstn) sense_en <= 1'b1;
      else       sense_en <= (next_state != sleep_ctl_pkg::ST_INACT);
   end

   // timer wake event that starts the motion check
   always_ff @(posedge mclk) begin
      if (!rstn) wake_pulse <= 1'b0;
      else       wake_pulse <= (state == sleep_ctl_pkg::ST_INACT)
                               && (next_state == sleep_ctl_pkg::ST_CHECK);
   end

   assign mode      = state;
   assign level_out = level;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   sequence s_check_to_track;
      state == sleep_ctl_pkg::ST_CHECK ##1 state == sleep_ctl_pkg::ST_TRACK;
   endsequence

   sequence s_check_to_inact;
      state == sleep_ctl_pkg::ST_CHECK ##1 state == sleep_ctl_pkg::ST_INACT;
   endsequence

   sequence s_inact_to_check;
      state == sleep_ctl_pkg::ST_INACT ##1 state == sleep_ctl_pkg::ST_CHECK;
   endsequence

   chk_disabled_track: assert property (
      !enable |=> state == sleep_ctl_pkg::ST_TRACK && level == 2'h0)
      else $error("disabled controller left tracking");

   chk_inact_sense: assert property (
      state == sleep_ctl_pkg::ST_INACT |-> !sense_en)
      else $error("sensing on while inactive");

   chk_track_sense: assert property (
      state != sleep_ctl_pkg::ST_INACT |-> sense_en)
      else $error("sensing off outside inactive");

   chk_wake_pulse: assert property (
      s_inact_to_check |-> wake_pulse)
      else $error("no wake pulse at check start");

   chk_sleep_len: assert property (
      s_inact_to_check |-> $past(ms_cnt) >= $past(pb.fsm_sleep))
      else $error("left inactive before sleep time");

   chk_motion_wake: assert property (
      s_check_to_track |-> level == 2'h0)
      else $error("tracking entered without level restart");

   chk_below_thresh: assert property (
      s_check_to_inact |-> $past(accum) < {1'b0, $past(pb.fsm_thresh)})
      else $error("returned to sleep with enough motion");

   chk_check_len: assert property (
      s_check_to_inact |-> $past(chk_cnt) == CHK_LAST)
      else $error("motion check ended early");

   chk_level_step: assert property (
      level != $past(level) && level != 2'h0
      |-> level == $past(level) + 2'h1
          && $past(state) == sleep_ctl_pkg::ST_CHECK)
      else $error("level changed out of sequence");

   chk_last_level: assert property (
      level == LAST_LVL && enable
      |=> level == LAST_LVL || state == sleep_ctl_pkg::ST_TRACK)
      else $error("left last level without motion");

   // wake, check outcome, level stepping and read data; each guard is
   // gated by enable where a disable write may override the sequencer

   chk_wake_single: assert property (
      wake_pulse |=> !wake_pulse)
      else $error("wake pulse longer than one cycle");

   chk_wake_cause: assert property (
      wake_pulse
      |-> state == sleep_ctl_pkg::ST_CHECK && $past(state) == sleep_ctl_pkg::ST_INACT)
      else $error("wake pulse without timer wake");

   chk_inact_ignore: assert property (
      state == sleep_ctl_pkg::ST_INACT |=> accum == '0)
      else $error("motion gathered while inactive");

   chk_sleep_hold: assert property (
      state == sleep_ctl_pkg::ST_INACT && enable && ms_cnt < pb.fsm_sleep
      |=> state == sleep_ctl_pkg::ST_INACT)
      else $error("inactive cut short");

   chk_thresh_wake: assert property (
      state == sleep_ctl_pkg::ST_CHECK && enable && accum >= {1'b0, pb.fsm_thresh}
      |=> state == sleep_ctl_pkg::ST_TRACK && level == 2'h0)
      else $error("enough motion did not wake");

   chk_inact_no_track: assert property (
      state == sleep_ctl_pkg::ST_INACT && enable |=> state != sleep_ctl_pkg::ST_TRACK)
      else $error("tracking entered without a motion check");

   chk_quiet_return: assert property (
      state == sleep_ctl_pkg::ST_CHECK && enable && chk_cnt == CHK_LAST
      && accum < {1'b0, pb.fsm_thresh}
      |=> state == sleep_ctl_pkg::ST_INACT)
      else $error("quiet check did not return inactive");

   chk_resid_step: assert property (
      state == sleep_ctl_pkg::ST_CHECK && enable && chk_cnt == CHK_LAST
      && accum < {1'b0, pb.fsm_thresh} && res_cnt >= pb.fsm_resid && level != LAST_LVL
      |=> level == $past(level) + 2'h1)
      else $error("residence used up without level step");

   chk_resid_hold: assert property (
      state == sleep_ctl_pkg::ST_CHECK && res_cnt < pb.fsm_resid
      |=> level == $past(level) || level == 2'h0)
      else $error("level stepped before residence ended");

   chk_mode_onehot: assert property (
      $onehot(state))
      else $error("mode register not one-hot");

   chk_track_level: assert property (
      state == sleep_ctl_pkg::ST_TRACK |-> level == 2'h0)
      else $error("tracking with a sleep level kept");

   chk_track_stay: assert property (
      state == sleep_ctl_pkg::ST_TRACK && motion_valid |=> state == sleep_ctl_pkg::ST_TRACK)
      else $error("left tracking while motion reported");

   chk_rdata_idle: assert property (
      !$past(rd) |-> rdata == 32'h0000_0000)
      else $error("read data outside the cycle after a read");
endmodule

`default_nettype wire

// file: verif/motion_front_model.sv
// front end model: sends one motion report per burst of sensing
// assumes the controller's clock; the bench sets size, delay and whether to report
`timescale 1ns/100ps
`default_nettype none

module motion_front_model (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rstn,
   // bench control
   input  wire logic        req,
   input  wire logic [15:0] req_mag,
   input  wire logic [3:0]  gap,
   // controller side
   input  wire logic        sense_en,
   output logic             motion_valid,
   output logic      [15:0] motion_mag
);
   logic       sense_d;
   logic [3:0] cnt;

   // report only while sensing; idle data toggles so a stale value never looks fresh
   always_ff @(posedge mclk) begin
      sense_d      <= sense_en;
      motion_valid <= 1'b0;
      motion_mag   <= ~motion_mag;
      if (!rstn) begin
         cnt        <= 4'h0;
         motion_mag <= 16'h0000;
      end else if (sense_en && !sense_d) begin
         cnt <= gap;                                // delay sets prompt or slow answer
      end else if (cnt != 4'h0) begin
         cnt <= cnt - 4'h1;
         if (cnt == 4'h1 && req && sense_en) begin
            motion_valid <= 1'b1;
            motion_mag   <= req_mag;
         end
      end
   end
endmodule

`default_nettype wire

// file: verif/sleep_mode_controller_bench.sv
// self-checking bench for the sleep mode controller with a motion front end model
// assumes short tick and check counts so every sleep level is reached quickly
`timescale 1ns/100ps
`default_nettype none
`include "sleep_ctl_regs.svh"

module sleep_mode_controller_bench;
   localparam int TICK = 10;
   localparam int CHK  = 20;
   logic        mclk, rstn, wr, rd, motion_valid, sense_en, wake_pulse, req;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata, v, w;
   logic [15:0] motion_mag, req_mag;
   logic [3:0]  gap;
   logic [2:0]  mode;
   logic [1:0]  level_out;
   int          failures, num_checks, n;

   sleep_mode_controller #(.PW(16), .TICK_CYC(TICK), .CHECK_CYC(CHK)) DUT (
      .mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .motion_valid(motion_valid), .motion_mag(motion_mag), .sense_en(sense_en),
      .wake_pulse(wake_pulse), .mode(mode), .level_out(level_out));

   motion_front_model front (
      .mclk(mclk), .rstn(rstn), .req(req), .req_mag(req_mag), .gap(gap),
      .sense_en(sense_en), .motion_valid(motion_valid), .motion_mag(motion_mag));

   always #5 mclk = ~mclk;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // bus cycles: strobe for one cycle, read data taken in the cycle after
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      wr <= 1'b1; addr <= a; wdata <= d;
      @(posedge mclk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge mclk);
      rd <= 1'b1; addr <= a;
      @(posedge mclk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   function automatic logic [7:0] fld_addr(input int lvl, input int f);
      return `REG_LVL_FIRST + 8'(lvl * 16 + f * 4);
   endfunction

   // bounded wait for a mode, or for the wake pulse when m is zero
   task automatic wait_for(input logic [2:0] m, input int lim);
      n = 0;
      while (((m == 3'h0) ? wake_pulse !== 1'b1 : mode !== m) && n < lim) begin
         @(posedge mclk);
         #1 n++;
      end
      // a limit that runs out is a mismatch, so a missing event cannot slip by
      if (n >= lim) begin
         failures++;
         $display("wrong value at %0t: wait limit of %0d cycles reached", $time, lim);
      end
   endtask

   initial begin
      #500_000;
      failures++;
      end_sim();
   end

   initial begin
      mclk = 0; rstn = 0; wr = 0; rd = 0; addr = 8'h00; wdata = 32'h0000_0000;
      req = 0; req_mag = 16'h0000; gap = 4'h2; failures = 0; num_checks = 0;
      v = $urandom(59);
      repeat (6) @(posedge mclk);
      rstn <= 1'b1;
      #1 check({sense_en, wake_pulse, mode, level_out}, {2'b10, sleep_ctl_pkg::ST_TRACK, 2'b00});
      // reset values of every level set, then random write and read back
      for (int l = 0; l < 4; l++) begin
         rd_reg(fld_addr(l, 0), v); check(v, 32'h0000_0064);
         rd_reg(fld_addr(l, 1), v); check(v, 32'h0000_0001);
         rd_reg(fld_addr(l, 2), v); check(v, 32'h0000_03e8);
         rd_reg(fld_addr(l, 3), v); check(v, 32'h0000_0000);
      end
      rd_reg(`REG_CTRL, v); check(v, 32'h0000_0000);
      rd_reg(`REG_IDLE, v); check(v, 32'h0000_0064);
      for (int l = 0; l < 4; l++)
         for (int f = 0; f < 3; f++) begin
            w = {16'h0000, 16'($urandom)};
            wr_reg(fld_addr(l, f), w);
            rd_reg(fld_addr(l, f), v); check(v, w);
         end
      wr_reg(fld_addr(2, 3), 32'h0000_5a5a);
      rd_reg(fld_addr(2, 3), v); check(v, 32'h0000_0000);
      // disabled: idle time zero still keeps tracking
      wr_reg(`REG_IDLE, 32'h0000_0000);
      for (int l = 0; l < 4; l++) begin
         wr_reg(fld_addr(l, 0), (l == 0) ? 32'h0000_0002 : 32'h0000_0001);
         wr_reg(fld_addr(l, 1), 32'h0000_0005);
         wr_reg(fld_addr(l, 2), (l == 0) ? 32'h0000_03e8 : 32'h0000_0001);
      end
      repeat (60) @(posedge mclk);
      #1 check({sense_en, mode}, {1'b1, sleep_ctl_pkg::ST_TRACK});
      // enable: inactive, timer wake, quiet check back to inactive
      wr_reg(`REG_CTRL, 32'h0000_0001);
      wait_for(sleep_ctl_pkg::ST_INACT, 20);
      check({sense_en, mode}, {1'b0, sleep_ctl_pkg::ST_INACT});
      wait_for(3'h0, 4 * TICK);
      check({sense_en, mode}, {1'b1, sleep_ctl_pkg::ST_CHECK});
      wait_for(sleep_ctl_pkg::ST_INACT, CHK + 10);
      check(32'(n >= CHK - 1 && n <= CHK + 1), 32'h0000_0001);
      check({mode, level_out}, {sleep_ctl_pkg::ST_INACT, 2'b00});
      // motion one short of the threshold does not wake
      req <= 1'b1; req_mag <= 16'h0004; gap <= 4'($urandom_range(1, 9));
      wait_for(3'h0, 4 * TICK);
      wait_for(sleep_ctl_pkg::ST_INACT, CHK + 10);
      check(mode, sleep_ctl_pkg::ST_INACT);
      // motion at the threshold wakes fully
      req_mag <= 16'h0005; gap <= 4'($urandom_range(1, 9));
      wait_for(3'h0, 4 * TICK);
      wait_for(sleep_ctl_pkg::ST_TRACK, CHK + 10);
      check({mode, level_out}, {sleep_ctl_pkg::ST_TRACK, 2'b00});
      req <= 1'b0;
      // short residence: levels step on their own down to the last one
      wr_reg(fld_addr(0, 2), 32'h0000_0001);
      for (int l = 1; l < 5; l++) begin
         wait_for(sleep_ctl_pkg::ST_CHECK, 6 * TICK);
         wait_for(sleep_ctl_pkg::ST_INACT, CHK + 10);
         repeat (2) @(posedge mclk);
         #1 check(level_out, (l > 3) ? 2'd3 : 2'(l));
      end
      // status word while asleep at the last level: level in [5:4], mode in [2:0]
      rd_reg(`REG_STATUS, v);
      check(v, {26'h0, 2'd3, 1'b0, sleep_ctl_pkg::ST_INACT});
      // motion at the last level restarts from the first
      req <= 1'b1; req_mag <= 16'hffff;
      wait_for(sleep_ctl_pkg::ST_TRACK, 6 * TICK + CHK);
      check({mode, level_out}, {sleep_ctl_pkg::ST_TRACK, 2'b00});
      req <= 1'b0;
      // disable while asleep forces tracking at once
      wait_for(sleep_ctl_pkg::ST_INACT, 20);
      wr_reg(`REG_CTRL, 32'h0000_0000);
      repeat (2) @(posedge mclk);
      #1 check({sense_en, mode, level_out}, {1'b1, sleep_ctl_pkg::ST_TRACK, 2'b00});
      end_sim();
   end
endmodule

`default_nettype wire
